// ---- design/bififo_pkg.sv ----
// constants, types and decode functions for the mailbox and bus-matching block
`default_nettype none
package bififo_pkg;
  localparam int DATA_W = 36;                   // long word width
  localparam int DEPTH = 16;                    // words per direction
  localparam int PTR_W = 5;                     // pointer with wrap bit
  localparam int OFS_W = 4;                     // one offset value
  localparam int OFS_BITS = 16;                 // four offsets in a row
  localparam int OFS_CNT_W = 5;                 // serial bit counter
  localparam logic [OFS_W-1:0] OFS_DEFAULT = 4'h8;       // preset offset
  localparam logic [OFS_CNT_W-1:0] OFS_LAST = 5'h10;     // all bits loaded
  localparam logic [PTR_W-1:0] PTR_FULL = 5'h10;         // fill at full
  localparam logic [DATA_W-1:0] MASK_LONG = 36'hF_FFFF_FFFF;
  localparam logic [DATA_W-1:0] MASK_WORD = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] MASK_BYTE = 36'h0_0000_01FF;
  localparam logic [1:0] PART_ONE = 2'h0;       // last part, long word
  localparam logic [1:0] PART_TWO = 2'h1;       // last part, word bus
  localparam logic [1:0] PART_FOUR = 2'h3;      // last part, byte bus
  localparam logic [2:0] LANES = 3'h4;          // nine-bit lanes per word
  localparam logic [2:0] LANES_WORD = 3'h2;     // lanes per word transfer
  localparam logic [2:0] LANES_BYTE = 3'h1;     // lanes per byte transfer
  localparam logic [5:0] LANE_SH = 6'h09;       // bits per lane

  // port b bus width
  typedef enum logic [1:0] {SIZE_LONG, SIZE_WORD, SIZE_BYTE} bus_size_t;

  // control strobes of one port
  typedef struct packed {
    logic cs_n;            // chip select, active low
    logic write_not_read;  // high write, low read
    logic gate;            // transfer gate
    logic mail_select;     // high mailbox, low fifo
  } port_ctl_t;

  // bus-match low is long word; else size picks word or byte
  function automatic bus_size_t decode_size(input logic bm, input logic sz);
    return !bm ? SIZE_LONG : (sz ? SIZE_BYTE : SIZE_WORD);
  endfunction

  // usable data lines for a width
  function automatic logic [DATA_W-1:0] size_mask(input bus_size_t s);
    case (s)
      SIZE_WORD: return MASK_WORD;
      SIZE_BYTE: return MASK_BYTE;
      default:   return MASK_LONG;
    endcase
  endfunction

  // index of the last part of a long word
  function automatic logic [1:0] last_part(input bus_size_t s);
    case (s)
      SIZE_WORD: return PART_TWO;
      SIZE_BYTE: return PART_FOUR;
      default:   return PART_ONE;
    endcase
  endfunction

  // bit offset of part p inside the long word, by width and order
  function automatic logic [5:0] lane_shift(input bus_size_t s,
                                            input logic be,
                                            input logic [1:0] p);
    logic [2:0] n;
    logic [2:0] lane;
    n = (s == SIZE_WORD) ? LANES_WORD :
        (s == SIZE_BYTE) ? LANES_BYTE : LANES;
    lane = be ? 3'(LANES - 3'(n * (3'(p) + 3'h1))) : 3'(n * 3'(p));
    return 6'(lane) * LANE_SH;
  endfunction
endpackage
`default_nettype wire

// ---- design/mailbox_bus_match.sv ----
// mailbox registers, bus sizing and the two long-word queues
//
// Overview of operation
// - port a mailbox write stores a to b mail
// - a to b mail keeps only bus-width lines
// - port b mailbox write stores b to a mail
// - b to a mail keeps only bus-width lines
// - mail write drives its full flag low
// - writes ignored while mail flag low
// - outputs from mail or fifo by select
// - port b mail read frees a to b
// - port b mail read gives bus-width bits
// - port a mail read frees b to a
// - port a mail read gives bus-width bits
// - mail kept after read; order never applied
// - bus size taken at master reset end
// - bus-match low long; else size word/byte
// - byte order latched at master reset rise
// - queues hold long words; convert outside them
// - long read whole; parts read from holding
// - unused port b read lines read as zero
// - parts held, long word committed at last
// - unused port b write lines ignored
// - word reads: upper half first when big
// - byte writes: high lane first when big
// - queue writes refused until ready flags high
// - serial offsets loaded in fixed order
`default_nettype none
module mailbox_bus_match (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  // port a
  input  wire bififo_pkg::port_ctl_t        port_a_ctl,
  input  wire logic [bififo_pkg::DATA_W-1:0] port_a_data_in,
  output logic      [bififo_pkg::DATA_W-1:0] port_a_data_out,
  output logic                              port_a_data_oe,
  // port b
  input  wire bififo_pkg::port_ctl_t        port_b_ctl,
  input  wire logic [bififo_pkg::DATA_W-1:0] port_b_data_in,
  output logic      [bififo_pkg::DATA_W-1:0] port_b_data_out,
  output logic                              port_b_data_oe,
  // configuration and resets
  input  wire logic                         bus_match_select,
  input  wire logic                         size_select,
  input  wire logic                         big_endian_select,
  input  wire logic                         a_to_b_master_reset_n,
  input  wire logic                         b_to_a_master_reset_n,
  input  wire logic                         serial_program_enable,
  input  wire logic                         serial_offset_strobe,
  input  wire logic                         serial_offset_input,
  // flags and offsets
  output logic                              a_to_b_mail_full_n,
  output logic                              b_to_a_mail_full_n,
  output logic                              port_a_full_or_input_ready,
  output logic                              port_b_full_or_input_ready,
  output logic                              port_a_output_ready,
  output logic                              port_b_output_ready,
  output logic      [bififo_pkg::OFS_BITS-1:0] offset_values
);
  localparam int DW = bififo_pkg::DATA_W;
  localparam int PW = bififo_pkg::PTR_W;

  // configuration group
  bififo_pkg::bus_size_t size_reg, size_next;     // port b width
  logic be_reg, be_next;                          // byte order
  logic mr_prev_reg, mr_prev_next;                // both resets, last cycle
  logic ready_reg, ready_next;                    // setup finished
  logic serial_reg, serial_next;                  // serial offset mode
  logic [bififo_pkg::OFS_BITS-1:0] ofs_reg, ofs_next;
  logic [bififo_pkg::OFS_CNT_W-1:0] cnt_reg, cnt_next;
  logic mr_both;                                  // both resets released

  // transfer group
  logic [DW-1:0] mem1 [bififo_pkg::DEPTH];        // a to b long words
  logic [DW-1:0] mem2 [bififo_pkg::DEPTH];        // b to a long words
  logic [PW-1:0] wp1_reg, wp1_next, rp1_reg, rp1_next;
  logic [PW-1:0] wp2_reg, wp2_next, rp2_reg, rp2_next;
  logic [DW-1:0] port_a_to_b_mail_reg, port_a_to_b_mail_next, port_b_to_a_mail_reg, port_b_to_a_mail_next;
  logic mf1_reg, mf1_next, mf2_reg, mf2_next;     // mail full, low = mail
  logic [DW-1:0] aux1_reg, aux1_next;             // rest of a read word
  logic [DW-1:0] aux2_reg, aux2_next;             // parts of a write word
  logic [1:0] part1_reg, part1_next, part2_reg, part2_next;
  logic [DW-1:0] f1out_reg, f1out_next;           // port b fifo output
  logic [DW-1:0] f2out_reg, f2out_next;           // port a fifo output
  logic [DW-1:0] aout_reg, aout_next, bout_reg, bout_next;
  logic aoe_reg, aoe_next, boe_reg, boe_next;
  logic ffa_reg, ffa_next, ffb_reg, ffb_next;     // room to write
  logic ora_reg, ora_next, orb_reg, orb_next;     // data to read
  logic m1_we, m2_we;                             // memory write enables
  logic [DW-1:0] m2_wdata;                        // assembled long word

  // decoded strobes
  logic a_sel, b_sel, a_mwr, a_mrd, b_mwr, b_mrd;
  logic a_fwr, a_frd, b_fwr, b_frd;
  logic [DW-1:0] mask, rd_word, wr_word;
  logic [5:0] sh1, sh2;
  logic [1:0] last;

  assign mr_both = a_to_b_master_reset_n & b_to_a_master_reset_n;
  assign mask = bififo_pkg::size_mask(size_reg);
  assign last = bififo_pkg::last_part(size_reg);
  assign sh1 = bififo_pkg::lane_shift(size_reg, be_reg, part1_reg);
  assign sh2 = bififo_pkg::lane_shift(size_reg, be_reg, part2_reg);
  assign a_sel = !port_a_ctl.cs_n & port_a_ctl.gate;
  assign b_sel = !port_b_ctl.cs_n & port_b_ctl.gate;
  assign a_mwr = a_sel & port_a_ctl.write_not_read & port_a_ctl.mail_select;
  assign a_mrd = a_sel & !port_a_ctl.write_not_read & port_a_ctl.mail_select;
  assign b_mwr = b_sel & port_b_ctl.write_not_read & port_b_ctl.mail_select;
  assign b_mrd = b_sel & !port_b_ctl.write_not_read & port_b_ctl.mail_select;
  // queue strobes gated by the flags, so setup refuses writes
  assign a_fwr = a_sel & port_a_ctl.write_not_read
               & !port_a_ctl.mail_select & ffa_reg;
  assign a_frd = a_sel & !port_a_ctl.write_not_read
               & !port_a_ctl.mail_select & ora_reg;
  assign b_fwr = b_sel & port_b_ctl.write_not_read
               & !port_b_ctl.mail_select & ffb_reg;
  assign b_frd = b_sel & !port_b_ctl.write_not_read
               & !port_b_ctl.mail_select & orb_reg;
  // a new read fetches from memory, later parts from the holding word
  assign rd_word = (part1_reg == '0) ? mem1[rp1_reg[PW-2:0]] : aux1_reg;
  // merge a write part into its lane; unused lines dropped
  assign wr_word = (aux2_reg & ~(mask << sh2))
                 | ((port_b_data_in & mask) << sh2);

  // configuration next state
  always_comb begin
    size_next = size_reg;
    be_next = be_reg;
    mr_prev_next = mr_both;
    ready_next = ready_reg;
    serial_next = serial_reg;
    ofs_next = ofs_reg;
    cnt_next = cnt_reg;
    if (!mr_both) begin
      // held in reset: presets loaded, mode sampled
      ready_next = 1'b0;
      cnt_next = '0;
      serial_next = serial_program_enable;
      ofs_next = {4{bififo_pkg::OFS_DEFAULT}};
    end else begin
      if (!mr_prev_reg) begin
        be_next = big_endian_select;
        size_next = bififo_pkg::decode_size(bus_match_select,
                                            size_select);
      end
      if (serial_reg && cnt_reg != bififo_pkg::OFS_LAST
          && serial_offset_strobe) begin
        // first bit ends at the top: a-b full, a-b empty, b-a full, b-a empty
        ofs_next = {ofs_reg[bififo_pkg::OFS_BITS-2:0],
                    serial_offset_input};
        cnt_next = cnt_reg + 1'b1;
      end
      ready_next = mr_prev_reg
                 && (!serial_reg || cnt_reg == bififo_pkg::OFS_LAST);
    end
  end

  // configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      size_reg <= bififo_pkg::SIZE_LONG;
      be_reg <= 1'b0;
      mr_prev_reg <= 1'b1;  // idle level: no false release after reset
      ready_reg <= 1'b0;
      serial_reg <= 1'b0;
      ofs_reg <= '0;
      cnt_reg <= '0;
    end else begin
      size_reg <= size_next;
      be_reg <= be_next;
      mr_prev_reg <= mr_prev_next;
      ready_reg <= ready_next;
      serial_reg <= serial_next;
      ofs_reg <= ofs_next;
      cnt_reg <= cnt_next;
    end
  end

  // transfer next state
  always_comb begin
    wp1_next = wp1_reg;
    rp1_next = rp1_reg;
    wp2_next = wp2_reg;
    rp2_next = rp2_reg;
    port_a_to_b_mail_next = port_a_to_b_mail_reg;
    port_b_to_a_mail_next = port_b_to_a_mail_reg;
    mf1_next = mf1_reg;
    mf2_next = mf2_reg;
    aux1_next = aux1_reg;
    aux2_next = aux2_reg;
    part1_next = part1_reg;
    part2_next = part2_reg;
    f1out_next = f1out_reg;
    f2out_next = f2out_reg;
    m1_we = 1'b0;
    m2_we = 1'b0;
    m2_wdata = wr_word;
    // reads free the mail first; a write in the same cycle is taken only if the flag was already high, and then wins
    if (b_mrd) mf1_next = 1'b1;
    if (a_mrd) mf2_next = 1'b1;
    if (a_mwr && mf1_reg) begin
      port_a_to_b_mail_next = port_a_data_in & mask;
      mf1_next = 1'b0;
    end
    if (b_mwr && mf2_reg) begin
      port_b_to_a_mail_next = port_b_data_in & mask;
      mf2_next = 1'b0;
    end
    // a to b queue: whole words in, parts out on port b
    if (a_fwr) begin
      m1_we = 1'b1;
      wp1_next = wp1_reg + 1'b1;
    end
    if (b_frd) begin
      if (part1_reg == '0) rp1_next = rp1_reg + 1'b1;
      aux1_next = rd_word;
      f1out_next = (rd_word >> sh1) & mask;
      part1_next = (part1_reg == last) ? 2'h0 : part1_reg + 1'b1;
    end
    // b to a queue: parts in on port b, whole words out on port a
    if (b_fwr) begin
      if (part2_reg == last) begin
        m2_we = 1'b1;
        wp2_next = wp2_reg + 1'b1;
        part2_next = 2'h0;
      end else begin
        aux2_next = wr_word;
        part2_next = part2_reg + 1'b1;
      end
    end
    if (a_frd) begin
      f2out_next = mem2[rp2_reg[PW-2:0]];
      rp2_next = rp2_reg + 1'b1;
    end
    // master resets empty their queue and free their mail
    if (!a_to_b_master_reset_n) begin
      wp1_next = '0;
      rp1_next = '0;
      part1_next = 2'h0;
      mf1_next = 1'b1;
    end
    if (!b_to_a_master_reset_n) begin
      wp2_next = '0;
      rp2_next = '0;
      part2_next = 2'h0;
      mf2_next = 1'b1;
    end
    // data lines pick mail or fifo output register
    aout_next = port_a_ctl.mail_select ? port_b_to_a_mail_reg & mask
                                       : f2out_next;
    bout_next = port_b_ctl.mail_select ? port_a_to_b_mail_reg & mask
                                       : f1out_next;
    aoe_next = !port_a_ctl.cs_n & !port_a_ctl.write_not_read;
    boe_next = !port_b_ctl.cs_n & !port_b_ctl.write_not_read;
    // flags from the next pointers
    ffa_next = ready_reg && (PW'(wp1_next - rp1_next) != bififo_pkg::PTR_FULL);
    ffb_next = ready_reg && (PW'(wp2_next - rp2_next) != bififo_pkg::PTR_FULL);
    ora_next = wp2_next != rp2_next;
    orb_next = (wp1_next != rp1_next) || (part1_next != 2'h0);
  end

  // transfer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp1_reg <= '0;
      rp1_reg <= '0;
      wp2_reg <= '0;
      rp2_reg <= '0;
      port_a_to_b_mail_reg <= '0;
      port_b_to_a_mail_reg <= '0;
      mf1_reg <= 1'b1;
      mf2_reg <= 1'b1;
      aux1_reg <= '0;
      aux2_reg <= '0;
      part1_reg <= 2'h0;
      part2_reg <= 2'h0;
      f1out_reg <= '0;
      f2out_reg <= '0;
      aout_reg <= '0;
      bout_reg <= '0;
      aoe_reg <= 1'b0;
      boe_reg <= 1'b0;
      ffa_reg <= 1'b0;
      ffb_reg <= 1'b0;
      ora_reg <= 1'b0;
      orb_reg <= 1'b0;
    end else begin
      wp1_reg <= wp1_next;
      rp1_reg <= rp1_next;
      wp2_reg <= wp2_next;
      rp2_reg <= rp2_next;
      port_a_to_b_mail_reg <= port_a_to_b_mail_next;
      port_b_to_a_mail_reg <= port_b_to_a_mail_next;
      mf1_reg <= mf1_next;
      mf2_reg <= mf2_next;
      aux1_reg <= aux1_next;
      aux2_reg <= aux2_next;
      part1_reg <= part1_next;
      part2_reg <= part2_next;
      f1out_reg <= f1out_next;
      f2out_reg <= f2out_next;
      aout_reg <= aout_next;
      bout_reg <= bout_next;
      aoe_reg <= aoe_next;
      boe_reg <= boe_next;
      ffa_reg <= ffa_next;
      ffb_reg <= ffb_next;
      ora_reg <= ora_next;
      orb_reg <= orb_next;
    end
  end

  // queue memories, no reset
  always_ff @(posedge clock) begin
    if (m1_we) mem1[wp1_reg[PW-2:0]] <= port_a_data_in;
    if (m2_we) mem2[wp2_reg[PW-2:0]] <= m2_wdata;
  end

  // outputs straight from flip-flops
  assign port_a_data_out = aout_reg;
  assign port_a_data_oe = aoe_reg;
  assign port_b_data_out = bout_reg;
  assign port_b_data_oe = boe_reg;
  assign a_to_b_mail_full_n = mf1_reg;
  assign b_to_a_mail_full_n = mf2_reg;
  assign port_a_full_or_input_ready = ffa_reg;
  assign port_b_full_or_input_ready = ffb_reg;
  assign port_a_output_ready = ora_reg;
  assign port_b_output_ready = orb_reg;
  assign offset_values = ofs_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_reset_held;
    !mr_both [*2];
  endsequence
  sequence s_word_big_read;
    size_reg == bififo_pkg::SIZE_WORD && be_reg && b_frd
      && part1_reg == 2'h0 && !port_b_ctl.mail_select;
  endsequence

  AST_PORT_A_TO_B_MAIL_WRITE: assert property (a_mwr && mf1_reg && mr_both |=>
    !a_to_b_mail_full_n && port_a_to_b_mail_reg == $past(port_a_data_in & mask))
    else $error("a to b mail write not taken");
  AST_PORT_A_TO_B_MAIL_HOLD: assert property (!mf1_reg |=> $stable(port_a_to_b_mail_reg))
    else $error("a to b mail changed while full");
  AST_PORT_A_TO_B_MAIL_FREE: assert property (b_mrd && !(a_mwr && mf1_reg)
    |=> mf1_reg)
    else $error("port b mail read did not free flag");
  AST_PORT_B_TO_A_MAIL_FREE: assert property (a_mrd && !(b_mwr && mf2_reg)
    |=> mf2_reg)
    else $error("port a mail read did not free flag");
  AST_BOUT_MAIL: assert property (b_mrd |=>
    port_b_data_out == $past(port_a_to_b_mail_reg & mask))
    else $error("port b mail data wrong");
  AST_WORD_ORDER: assert property (s_word_big_read |=>
    port_b_data_out[17:0] == $past(rd_word[35:18]))
    else $error("big word read not upper half first");
  AST_READY_LOW: assert property (s_reset_held |=>
    !port_a_full_or_input_ready && !port_b_full_or_input_ready)
    else $error("ready flag high during reset");
  AST_BE_LATCH: assert property (mr_both && !mr_prev_reg |=>
    be_reg == $past(big_endian_select))
    else $error("byte order not latched");
  AST_COMMIT: assert property (b_fwr && part2_reg == last
    && mr_both |=> wp2_reg == $past(wp2_reg) + 1'b1)
    else $error("long word not committed");
  AST_MAIL_RESET: assert property (!a_to_b_master_reset_n |=> mf1_reg)
    else $error("master reset kept mail flag low");
endmodule // mailbox_bus_match
`default_nettype wire

// ---- dv/bus_host.sv ----
// bus host model that drives one data port of the mailbox block
`default_nettype none
module bus_host (
  // clock
  input  wire logic                          clock,
  // strobes and data toward the block
  output bififo_pkg::port_ctl_t              ctl,
  output logic      [bififo_pkg::DATA_W-1:0] data_in,
  // answers from the block
  input  wire logic [bififo_pkg::DATA_W-1:0] data_out,
  input  wire logic                          in_ready,
  input  wire logic                          out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle at time zero: deselected, lines parked
  initial begin
    ctl = '{cs_n: 1'b1, default: 1'b0};
    data_in = '0;
  end

  // one transfer; queue ops wait for the ready flag first
  task automatic xfer(input logic wr, input logic mail,
                      input logic [bififo_pkg::DATA_W-1:0] d,
                      output logic [bififo_pkg::DATA_W-1:0] q,
                      output logic ok);
    int n;
    n = 0;
    @(posedge clock);
    // queue access only while its flag allows it
    while (!mail && (wr ? in_ready : out_ready) !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    ok = (n < 200);
    // strobes and data held for the taking edge
    ctl <= '{cs_n: 1'b0, write_not_read: wr, gate: 1'b1,
             mail_select: mail};
    data_in <= d;
    @(posedge clock);
    // released lines show the inverse of the last value
    ctl <= '{cs_n: 1'b1, default: 1'b0};
    data_in <= ~d;
    #1;
    q = data_out;
  endtask
endmodule // bus_host
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the mailbox and bus-matching block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 6000;  // cycle ceiling for the run
  localparam logic [35:0] MAIL_1 = 36'hA_5C3E_97B1;  // mail patterns
  localparam logic [35:0] MAIL_2 = 36'h3_1234_5678;
  localparam logic [35:0] WORD_1 = 36'h9_8765_4321;  // queue patterns
  localparam logic [35:0] WORD_2 = 36'h6_1357_9BDF;
  // {bus match, size, byte order}: long, word big/little, byte big/little
  localparam logic [2:0] CFGS [5] = '{3'h0, 3'h5, 3'h4, 3'h7, 3'h6};
  // clock, resets and straps
  logic                  clock;
  logic                  rst_b;
  logic                  bus_match_select;
  logic                  size_select;
  logic                  big_endian_select;
  logic                  a_to_b_master_reset_n;
  logic                  b_to_a_master_reset_n;
  // serial offset load
  logic                  serial_program_enable;
  logic                  serial_offset_strobe;
  logic                  serial_offset_input;
  logic [15:0]           offset_values;
  // ports
  bififo_pkg::port_ctl_t port_a_ctl;
  bififo_pkg::port_ctl_t port_b_ctl;
  logic [35:0]           port_a_data_in;
  logic [35:0]           port_a_data_out;
  logic                  port_a_data_oe;
  logic [35:0]           port_b_data_in;
  logic [35:0]           port_b_data_out;
  logic                  port_b_data_oe;
  // flags
  logic                  a_to_b_mail_full_n;
  logic                  b_to_a_mail_full_n;
  logic                  port_a_full_or_input_ready;
  logic                  port_b_full_or_input_ready;
  logic                  port_a_output_ready;
  logic                  port_b_output_ready;
  // bookkeeping
  int                    mismatches = 0;
  int                    check_count = 0;
  int                    cycles = 0;

  // block under test
  mailbox_bus_match mailbox_bus_match_inst (
    .clock(clock), .rst_b(rst_b),
    .port_a_ctl(port_a_ctl), .port_a_data_in(port_a_data_in),
    .port_a_data_out(port_a_data_out), .port_a_data_oe(port_a_data_oe),
    .port_b_ctl(port_b_ctl), .port_b_data_in(port_b_data_in),
    .port_b_data_out(port_b_data_out), .port_b_data_oe(port_b_data_oe),
    .bus_match_select(bus_match_select), .size_select(size_select),
    .big_endian_select(big_endian_select),
    .a_to_b_master_reset_n(a_to_b_master_reset_n),
    .b_to_a_master_reset_n(b_to_a_master_reset_n),
    .serial_program_enable(serial_program_enable),
    .serial_offset_strobe(serial_offset_strobe),
    .serial_offset_input(serial_offset_input),
    .a_to_b_mail_full_n(a_to_b_mail_full_n),
    .b_to_a_mail_full_n(b_to_a_mail_full_n),
    .port_a_full_or_input_ready(port_a_full_or_input_ready),
    .port_b_full_or_input_ready(port_b_full_or_input_ready),
    .port_a_output_ready(port_a_output_ready),
    .port_b_output_ready(port_b_output_ready),
    .offset_values(offset_values));

  // host on each port
  bus_host port_a_host (.clock(clock), .ctl(port_a_ctl),
    .data_in(port_a_data_in), .data_out(port_a_data_out),
    .in_ready(port_a_full_or_input_ready), .out_ready(port_a_output_ready));
  bus_host port_b_host (.clock(clock), .ctl(port_b_ctl),
    .data_in(port_b_data_in), .data_out(port_b_data_out),
    .in_ready(port_b_full_or_input_ready), .out_ready(port_b_output_ready));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // count one comparison, report a mismatch
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // bit offset of part p for a configuration
  function automatic int shift_of(input logic [2:0] c, input int p);
    int n;
    n = !c[2] ? 4 : (c[1] ? 1 : 2);
    return 9 * (c[0] ? 4 - n * (p + 1) : n * p);
  endfunction

  // master reset with straps, then wait for both ready flags
  task automatic master_reset(input logic [2:0] c);
    int n;
    n = 0;
    @(posedge clock);
    {bus_match_select, size_select, big_endian_select} <= c;
    a_to_b_master_reset_n <= 1'b0;
    b_to_a_master_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    // both queues released together
    a_to_b_master_reset_n <= 1'b1;
    b_to_a_master_reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    big_endian_select <= ~c[0];  // order must stay as latched
    while ({port_a_full_or_input_ready, port_b_full_or_input_ready}
           !== 2'b11 && n < 20) begin
      @(posedge clock);
      n++;
    end
    check(36'(n < 20), 36'h1);
  endtask

  // serial offset load: presets first, port a flag held low until all bits, both flags high after
  task automatic serial_load(input logic [15:0] v);
    @(posedge clock);
    serial_program_enable <= 1'b1;
    a_to_b_master_reset_n <= 1'b0;
    b_to_a_master_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    a_to_b_master_reset_n <= 1'b1;
    b_to_a_master_reset_n <= 1'b1;
    serial_program_enable <= 1'b0;
    repeat (3) @(posedge clock);
    check(36'(offset_values), 36'({4{bififo_pkg::OFS_DEFAULT}}));
    for (int i = 15; i >= 0; i--) begin
      // one bit every other clock: strobes need not be back to back
      serial_offset_input <= v[i];
      serial_offset_strobe <= 1'b1;
      @(posedge clock);
      serial_offset_strobe <= 1'b0;
      @(posedge clock);
      check(36'(port_a_full_or_input_ready), 36'h0);
    end
    repeat (3) @(posedge clock);
    check(36'(offset_values), 36'(v));
    check(36'({port_a_full_or_input_ready, port_b_full_or_input_ready}),
          36'h3);
  endtask

  // mailboxes and both queues under one bus configuration
  task automatic run_config(input logic [2:0] c);
    logic [35:0] mask;
    logic [35:0] q;
    logic        ok;
    int          parts;
    mask = !c[2] ? 36'hF_FFFF_FFFF :
           (c[1] ? 36'h0_0000_01FF : 36'h0_0003_FFFF);
    parts = !c[2] ? 1 : (c[1] ? 4 : 2);
    master_reset(c);
    check(36'(a_to_b_mail_full_n), 36'h1);
    // a to b mail; second write is refused
    port_a_host.xfer(1'b1, 1'b1, MAIL_1, q, ok);
    check(36'(a_to_b_mail_full_n), 36'h0);
    port_a_host.xfer(1'b1, 1'b1, MAIL_2, q, ok);
    port_b_host.xfer(1'b0, 1'b1, '0, q, ok);
    check(q, MAIL_1 & mask);
    check(36'({port_b_data_oe, a_to_b_mail_full_n}), 36'h3);
    port_b_host.xfer(1'b0, 1'b1, '0, q, ok);
    check(q, MAIL_1 & mask);
    // b to a mail
    port_b_host.xfer(1'b1, 1'b1, MAIL_2, q, ok);
    check(36'(b_to_a_mail_full_n), 36'h0);
    port_a_host.xfer(1'b0, 1'b1, '0, q, ok);
    check(q, MAIL_2 & mask);
    check(36'({port_a_data_oe, b_to_a_mail_full_n}), 36'h3);
    // a to b queue read back in parts
    port_a_host.xfer(1'b1, 1'b0, WORD_1, q, ok);
    check(36'(ok), 36'h1);
    for (int p = 0; p < parts; p++) begin
      port_b_host.xfer(1'b0, 1'b0, '0, q, ok);
      check(q, (WORD_1 >> shift_of(c, p)) & mask);
      check(36'(ok), 36'h1);
    end
    // b to a queue written in parts, junk on unused lines
    for (int p = 0; p < parts; p++) begin
      port_b_host.xfer(1'b1, 1'b0, ((WORD_2 >> shift_of(c, p)) & mask) |
                       (~mask & MAIL_1), q, ok);
      check(36'(ok), 36'h1);
    end
    port_a_host.xfer(1'b0, 1'b0, '0, q, ok);
    check(q, WORD_2);
    // leave a to b mail full for the next master reset to free
    port_a_host.xfer(1'b1, 1'b1, MAIL_2, q, ok);
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    bus_match_select = 1'b0;
    size_select = 1'b0;
    big_endian_select = 1'b0;
    a_to_b_master_reset_n = 1'b1;
    b_to_a_master_reset_n = 1'b1;
    serial_program_enable = 1'b0;
    serial_offset_strobe = 1'b0;
    serial_offset_input = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    check(36'({a_to_b_mail_full_n, b_to_a_mail_full_n}), 36'h3);
    serial_load(16'h3C5A);
    for (int i = 0; i < 5; i++) begin
      run_config(CFGS[i]);
    end
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
